// ==== bss_pkg.sv ====
// constants, codes and types shared by the burner safety sequencer
package bss_pkg;

    // system clock 20 MHz, one-second sequencing tick
    localparam int unsigned CLK_HZ = 32'h0131_2D00;
    localparam int unsigned TICK_PERIOD_S = 32'h0000_0001;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam logic [24:0] TICK_CNT_RST = 25'h000_0000;

    // phase times in seconds; the phase timer counts whole ticks
    localparam logic [7:0] PREPURGE_TIME_S = 8'h0F;
    localparam logic [7:0] STRAY_LIGHT_WINDOW_S = 8'h05;
    localparam logic [7:0] FLAME_SAFETY_TIME_S = 8'h07;
    localparam logic [7:0] POST_IGNITION_TIME_S = 8'h09;
    localparam logic [7:0] SECOND_VALVE_DELAY_S = 8'h16;
    localparam logic [7:0] POST_PURGE_TIME_S = 8'h14;
    localparam logic [7:0] POWERUP_TIME_S = 8'h01;
    localparam logic [7:0] LOCKOUT_RESET_S = 8'h3C;
    localparam logic [2:0] MANUAL_HOLD_S = 3'h3;

    // derived phase lengths, all counted from the phase's own entry
    localparam logic [7:0] PREPURGE_ONLY_S =
        PREPURGE_TIME_S - STRAY_LIGHT_WINDOW_S;
    localparam logic [7:0] POSTIGN_IGN_S =
        POST_IGNITION_TIME_S - FLAME_SAFETY_TIME_S;
    localparam logic [7:0] POSTIGN_TIME_S =
        SECOND_VALVE_DELAY_S - FLAME_SAFETY_TIME_S;

    localparam logic [7:0] PHASE_TMR_RST = 8'h00;
    localparam logic [7:0] PHASE_TMR_MAX = 8'hFF;
    localparam logic [2:0] HOLD_SEC_RST = 3'h0;
    localparam logic [2:0] HOLD_SEC_MAX = 3'h7;
    localparam logic [2:0] NVM_SETTLE_CYCLES = 3'h4;

    // two-digit display codes, packed BCD
    localparam logic [7:0] CODE_POWERUP = 8'h01;
    localparam logic [7:0] CODE_READY = 8'h02;
    localparam logic [7:0] CODE_PREPURGE = 8'h03;
    localparam logic [7:0] CODE_STRAY = 8'h04;
    localparam logic [7:0] CODE_IGNITION = 8'h05;
    localparam logic [7:0] CODE_POSTIGN = 8'h06;
    localparam logic [7:0] CODE_RUN = 8'h07;
    localparam logic [7:0] CODE_POSTPURGE = 8'h08;
    localparam logic [7:0] CODE_LOW_SUPPLY = 8'h10;
    localparam logic [7:0] CODE_MANUAL = 8'h11;
    localparam logic [7:0] CODE_FLAME_OFF = 8'h12;
    localparam logic [7:0] CODE_STRAY_LIGHT = 8'h13;
    localparam logic [7:0] CODE_NO_FLAME = 8'h14;
    localparam logic [7:0] CODE_RESETTABLE_ADD = 8'h10;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_LOW_SUPPLY = 3'h1,
        CAUSE_MANUAL = 3'h2,
        CAUSE_FLAME_OFF = 3'h3,
        CAUSE_STRAY_LIGHT = 3'h4,
        CAUSE_NO_FLAME = 3'h5
    } bss_cause_e;

    typedef enum logic [8:0] {
        ST_POWERUP = 9'h001,
        ST_READY = 9'h002,
        ST_PREPURGE = 9'h004,
        ST_STRAY = 9'h008,
        ST_IGNITION = 9'h010,
        ST_POSTIGN = 9'h020,
        ST_RUN = 9'h040,
        ST_POSTPURGE = 9'h080,
        ST_LOCKOUT = 9'h100
    } bss_state_e;

    // segment pattern, bit order g f e d c b a, active high
    function automatic logic [6:0] bss_seg7(input logic [3:0] digit);
        logic [6:0] seg;
        seg = 7'h00;
        case (digit)
            4'h0: seg = 7'h3F;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5B;
            4'h3: seg = 7'h4F;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6D;
            4'h6: seg = 7'h7D;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7F;
            4'h9: seg = 7'h6F;
            default: seg = 7'h40;
        endcase
        return seg;
    endfunction : bss_seg7

endpackage : bss_pkg

// ==== bss_nvm_if.sv ====
// link between the sequencer and the lockout cause store
interface bss_nvm_if import bss_pkg::*;;
    logic wrReq;
    bss_cause_e wrCause;
    bss_cause_e storedCause;
    logic loaded;

    modport seq (
        output wrReq,
        output wrCause,
        input storedCause,
        input loaded
    );
    modport store (
        input wrReq,
        input wrCause,
        output storedCause,
        output loaded
    );
endinterface : bss_nvm_if

// ==== bss_nvm_store.sv ====
// lockout cause store: reads back the external memory, drives its writes
module bss_nvm_store import bss_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] nvmCauseIn,
    bss_nvm_if.store nv,
    output logic nvmWrEn,
    output logic [2:0] nvmWrCause
);
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] settle_q;
    logic loaded_q;
    bss_cause_e stored_q;
    logic wrEn_q;
    logic [2:0] wrCause_q;
    logic settled;
    logic validCode;

    assign settled = (settle_q == NVM_SETTLE_CYCLES);
    assign validCode = (sync2_q <= CAUSE_NO_FLAME);

    always_ff @(posedge clk_sys) begin
        sync1_q <= nvmCauseIn;
        sync2_q <= sync1_q;
    end

    // sampled once after reset and settle, then follows every write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            settle_q <= HOLD_SEC_RST;
            loaded_q <= 1'b0;
            stored_q <= CAUSE_NONE;
        end else if (!settled) begin
            settle_q <= settle_q + 3'h1;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            stored_q <= validCode ? bss_cause_e'(sync2_q) : CAUSE_NONE;
        end else if (nv.wrReq) begin
            stored_q <= nv.wrCause;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrEn_q <= 1'b0;
            wrCause_q <= CAUSE_NONE;
        end else begin
            wrEn_q <= nv.wrReq;
            if (nv.wrReq) begin
                wrCause_q <= nv.wrCause;
            end
        end
    end

    assign nv.storedCause = stored_q;
    assign nv.loaded = loaded_q;
    assign nvmWrEn = wrEn_q;
    assign nvmWrCause = wrCause_q;

endmodule : bss_nvm_store

// ==== bss_sequencer.sv ====
// burner safety sequencer top: phases, lockout, display and outputs
// Function
// - prepurge 15 s, stray window 5 s, safety 7 s
// - ignition 9 s, second valve 22 s, postpurge 20 s
// - phase codes 01 through 08 on display
// - display follows the current phase, or shows the cause code in lockout
// - lockout cause codes 10 through 14
// - light during stray check locks out, code 13
// - lockout cause kept in non-volatile memory
// - one button resets lockout and forces lockout
// - no reset accepted before 60 s of lockout
// - flame loss while running recycles start-up
// - low supply interrupts and blocks restart
// - supply checked in every phase but power-up, running included
// - stray check ends prepurge, lasts its window
// - demand drop from ignition on post-purges; flame there after its first second locks out
// - resettable lockout shows codes 20 through 24
// - button held over 3 s, released, locks out from prepurge through post-purge
module bss_sequencer import bss_pkg::*; #(
    parameter int unsigned TICK_CYCLES = bss_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic heatDemand,
    input wire logic flameSeen,
    input wire logic buttonPressed,
    input wire logic supplyLow,
    input wire logic [2:0] nvmCauseIn,
    output logic motorOn,
    output logic ignitionOn,
    output logic firstFuelValve,
    output logic secondFuelValve,
    output logic alarmOn,
    output logic [7:0] dispCode,
    output logic [6:0] segTens,
    output logic [6:0] segOnes,
    output logic nvmWrEn,
    output logic [2:0] nvmWrCause
);
    localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

    bss_nvm_if nvLink ();

    // pin synchronisers: demand, flame, button, supply
    logic [3:0] pin1_q;
    logic [3:0] pin2_q;
    logic demand;
    logic flame;
    logic button;
    logic lowSupply;

    logic [24:0] tickCnt_q;
    logic tick;
    bss_state_e state_q;
    bss_state_e state_d;
    bss_cause_e cause_q;
    bss_cause_e cause_d;
    logic [7:0] phaseTmr_q;
    logic [7:0] phaseLimit;
    logic timeUp;
    logic phaseChange;
    logic buttonPrev_q;
    logic buttonRelease;
    logic [2:0] holdSec_q;
    logic manualReq;
    logic resettable;
    logic resetAccept;
    logic activeState;
    logic manualState;
    logic enterLockout;
    logic leaveLockout;

    logic motor_d;
    logic ignition_d;
    logic valve1_d;
    logic valve2_d;
    logic [7:0] causeCode;
    logic [7:0] lockCode;
    logic [7:0] phaseCode;
    logic [7:0] disp_d;

    logic motorOn_q;
    logic ignitionOn_q;
    logic valve1_q;
    logic valve2_q;
    logic alarm_q;
    logic [7:0] disp_q;
    logic [6:0] segTens_q;
    logic [6:0] segOnes_q;

    always_ff @(posedge clk_sys) begin
        pin1_q <= {heatDemand, flameSeen, buttonPressed, supplyLow};
        pin2_q <= pin1_q;
    end

    assign demand = pin2_q[3];
    assign flame = pin2_q[2];
    assign button = pin2_q[1];
    assign lowSupply = pin2_q[0];

    bss_nvm_store u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .nvmCauseIn(nvmCauseIn),
        .nv(nvLink.store),
        .nvmWrEn(nvmWrEn),
        .nvmWrCause(nvmWrCause)
    );

    // one-second tick, divider restarted on every phase entry
    assign phaseChange = (state_d != state_q);
    assign tick = (tickCnt_q == TICK_LAST);

    always_ff @(posedge clk_sys) begin
        if (rst || phaseChange || tick) begin
            tickCnt_q <= TICK_CNT_RST;
        end else begin
            tickCnt_q <= tickCnt_q + 25'h000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || phaseChange) begin
            phaseTmr_q <= PHASE_TMR_RST;
        end else if (tick && phaseTmr_q != PHASE_TMR_MAX) begin
            phaseTmr_q <= phaseTmr_q + 8'h01;
        end
    end

    assign phaseLimit =
        (state_q == ST_POWERUP) ? POWERUP_TIME_S :
        (state_q == ST_PREPURGE) ? PREPURGE_ONLY_S :
        (state_q == ST_STRAY) ? STRAY_LIGHT_WINDOW_S :
        (state_q == ST_IGNITION) ? FLAME_SAFETY_TIME_S :
        (state_q == ST_POSTIGN) ? POSTIGN_TIME_S :
        (state_q == ST_POSTPURGE) ? POST_PURGE_TIME_S :
        PHASE_TMR_MAX;
    assign timeUp = tick && (phaseTmr_q == phaseLimit - 8'h01);

    // push button: hold length in whole seconds, acted on at release
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buttonPrev_q <= 1'b0;
            holdSec_q <= HOLD_SEC_RST;
        end else begin
            buttonPrev_q <= button;
            if (!button) begin
                holdSec_q <= HOLD_SEC_RST;
            end else if (tick && holdSec_q != HOLD_SEC_MAX) begin
                holdSec_q <= holdSec_q + 3'h1;
            end
        end
    end

    assign buttonRelease = buttonPrev_q && !button;
    assign manualReq = buttonRelease && (holdSec_q > MANUAL_HOLD_S);
    assign resettable = (state_q == ST_LOCKOUT) &&
        (phaseTmr_q >= LOCKOUT_RESET_S);
    assign resetAccept = resettable && buttonRelease;

    assign activeState = (state_q != ST_LOCKOUT) &&
        (state_q != ST_POWERUP);
    assign manualState = activeState && (state_q != ST_READY);

    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        case (state_q)
            ST_POWERUP: begin
                if (nvLink.loaded && timeUp) begin
                    if (nvLink.storedCause != CAUSE_NONE) begin
                        state_d = ST_LOCKOUT;
                        cause_d = nvLink.storedCause;
                    end else begin
                        state_d = ST_READY;
                    end
                end
            end
            ST_READY: begin
                if (demand) begin
                    state_d = ST_PREPURGE;
                end
            end
            ST_PREPURGE: begin
                if (!demand) begin
                    state_d = ST_READY;
                end else if (timeUp) begin
                    state_d = ST_STRAY;
                end
            end
            ST_STRAY: begin
                if (flame) begin
                    state_d = ST_LOCKOUT;
                    cause_d = CAUSE_STRAY_LIGHT;
                end else if (!demand) begin
                    state_d = ST_READY;
                end else if (timeUp) begin
                    state_d = ST_IGNITION;
                end
            end
            ST_IGNITION: begin
                if (timeUp) begin
                    if (flame) begin
                        state_d = ST_POSTIGN;
                    end else begin
                        state_d = ST_LOCKOUT;
                        cause_d = CAUSE_NO_FLAME;
                    end
                end else if (!demand) begin
                    state_d = ST_POSTPURGE;
                end
            end
            ST_POSTIGN: begin
                if (!flame) begin
                    state_d = ST_READY;
                end else if (!demand) begin
                    state_d = ST_POSTPURGE;
                end else if (timeUp) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!flame) begin
                    state_d = ST_READY;
                end else if (!demand) begin
                    state_d = ST_POSTPURGE;
                end
            end
            ST_POSTPURGE: begin
                if (flame && (phaseTmr_q != PHASE_TMR_RST)) begin
                    state_d = ST_LOCKOUT;
                    cause_d = CAUSE_FLAME_OFF;
                end else if (timeUp) begin
                    state_d = ST_READY;
                end
            end
            ST_LOCKOUT: begin
                if (cause_q == CAUSE_LOW_SUPPLY) begin
                    if (!lowSupply) begin
                        state_d = ST_POWERUP;
                        cause_d = CAUSE_NONE;
                    end
                end else if (resetAccept) begin
                    state_d = ST_POWERUP;
                    cause_d = CAUSE_NONE;
                end
            end
            default: begin
                state_d = ST_LOCKOUT;
                cause_d = CAUSE_NO_FLAME;
            end
        endcase
        // supply lockout overrides every active phase, manual lockout all but ready
        if (activeState && lowSupply) begin
            state_d = ST_LOCKOUT;
            cause_d = CAUSE_LOW_SUPPLY;
        end else if (manualState && manualReq) begin
            state_d = ST_LOCKOUT;
            cause_d = CAUSE_MANUAL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_POWERUP;
            cause_q <= CAUSE_NONE;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
        end
    end

    // cause is written on lockout entry and cleared on leaving
    assign enterLockout = (state_d == ST_LOCKOUT) &&
        (state_q != ST_LOCKOUT);
    assign leaveLockout = (state_d != ST_LOCKOUT) &&
        (state_q == ST_LOCKOUT);
    assign nvLink.wrReq = enterLockout || leaveLockout;
    assign nvLink.wrCause = cause_d;

    // load drive; lockout drops everything, so post-purge is skipped
    assign motor_d = (state_q == ST_PREPURGE) || (state_q == ST_STRAY) ||
        (state_q == ST_IGNITION) || (state_q == ST_POSTIGN) ||
        (state_q == ST_RUN) || (state_q == ST_POSTPURGE);
    assign ignition_d = (state_q == ST_PREPURGE) ||
        (state_q == ST_STRAY) || (state_q == ST_IGNITION) ||
        ((state_q == ST_POSTIGN) && (phaseTmr_q < POSTIGN_IGN_S));
    assign valve1_d = (state_q == ST_IGNITION) ||
        (state_q == ST_POSTIGN) || (state_q == ST_RUN);
    assign valve2_d = (state_q == ST_RUN);

    assign causeCode =
        (cause_q == CAUSE_LOW_SUPPLY) ? CODE_LOW_SUPPLY :
        (cause_q == CAUSE_MANUAL) ? CODE_MANUAL :
        (cause_q == CAUSE_FLAME_OFF) ? CODE_FLAME_OFF :
        (cause_q == CAUSE_STRAY_LIGHT) ? CODE_STRAY_LIGHT :
        CODE_NO_FLAME;
    assign lockCode = resettable ?
        causeCode + CODE_RESETTABLE_ADD : causeCode;
    assign phaseCode =
        (state_q == ST_POWERUP) ? CODE_POWERUP :
        (state_q == ST_READY) ? CODE_READY :
        (state_q == ST_PREPURGE) ? CODE_PREPURGE :
        (state_q == ST_STRAY) ? CODE_STRAY :
        (state_q == ST_IGNITION) ? CODE_IGNITION :
        (state_q == ST_POSTIGN) ? CODE_POSTIGN :
        (state_q == ST_RUN) ? CODE_RUN :
        CODE_POSTPURGE;
    assign disp_d = (state_q == ST_LOCKOUT) ? lockCode : phaseCode;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            motorOn_q <= 1'b0;
            ignitionOn_q <= 1'b0;
            valve1_q <= 1'b0;
            valve2_q <= 1'b0;
            alarm_q <= 1'b0;
            disp_q <= CODE_POWERUP;
            segTens_q <= bss_seg7(CODE_POWERUP[7:4]);
            segOnes_q <= bss_seg7(CODE_POWERUP[3:0]);
        end else begin
            motorOn_q <= motor_d;
            ignitionOn_q <= ignition_d;
            valve1_q <= valve1_d;
            valve2_q <= valve2_d;
            alarm_q <= (state_q == ST_LOCKOUT);
            disp_q <= disp_d;
            segTens_q <= bss_seg7(disp_d[7:4]);
            segOnes_q <= bss_seg7(disp_d[3:0]);
        end
    end

    assign motorOn = motorOn_q;
    assign ignitionOn = ignitionOn_q;
    assign firstFuelValve = valve1_q;
    assign secondFuelValve = valve2_q;
    assign alarmOn = alarm_q;
    assign dispCode = disp_q;
    assign segTens = segTens_q;
    assign segOnes = segOnes_q;

endmodule : bss_sequencer

// ==== bss_burner_model.sv ====
// burner, photocell and lockout cause memory at the sequencer's far side
module bss_burner_model (
    input wire logic clk_sys,
    input wire logic ignitionOn,
    input wire logic firstFuelValve,
    input wire logic nvmWrEn,
    input wire logic [2:0] nvmWrCause,
    input wire logic noFuel,
    input wire logic strayLight,
    input wire logic valveLeak,
    output logic flameSeen,
    output logic [2:0] nvmCauseIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lit_q = 1'b0;
    logic [2:0] cause_q = 3'h0;
    logic litSet;
    logic burning;

    assign litSet = firstFuelValve && ignitionOn && !noFuel;
    assign burning = lit_q && firstFuelValve && !noFuel;
    assign flameSeen = burning || strayLight || valveLeak;
    assign nvmCauseIn = cause_q;

    always_ff @(posedge clk_sys) begin
        lit_q <= litSet || burning;
    end

    // no reset: contents survive a supply loss
    always_ff @(posedge clk_sys) begin
        if (nvmWrEn) begin
            cause_q <= nvmWrCause;
        end
    end
endmodule : bss_burner_model

// ==== bss_sequencer_properties.sv ====
// concurrent checks on the burner safety sequencer ports
module bss_seq_checker #(
    parameter int unsigned TICK_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic heatDemand,
    input wire logic flameSeen,
    input wire logic buttonPressed,
    input wire logic supplyLow,
    input wire logic [2:0] nvmCauseIn,
    input wire logic motorOn,
    input wire logic ignitionOn,
    input wire logic firstFuelValve,
    input wire logic secondFuelValve,
    input wire logic alarmOn,
    input wire logic [7:0] dispCode,
    input wire logic [6:0] segTens,
    input wire logic [6:0] segOnes,
    input wire logic nvmWrEn,
    input wire logic [2:0] nvmWrCause
);
    localparam int LOCK_CYC = 60 * TICK_CYCLES;
    localparam int V2_CYC = 22 * TICK_CYCLES;
    localparam int IGN_CYC = 9 * TICK_CYCLES;
    logic [31:0] lockCnt_q;
    logic [31:0] v1Cnt_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // cycles spent in lockout and with the first valve open
    always_ff @(posedge clk_sys) begin
        lockCnt_q <= (rst || !alarmOn) ? 32'h0000_0000
            : lockCnt_q + 32'h0000_0001;
        v1Cnt_q <= (rst || !firstFuelValve) ? 32'h0000_0000
            : v1Cnt_q + 32'h0000_0001;
    end

    a_lock_entry: assert property ($rose(alarmOn) |-> $past(nvmWrEn)
        && dispCode[7:4] == 4'h1 && nvmWrCause == dispCode[2:0] + 3'h1)
        else $error("lockout entered without cause write");
    a_lock_exit: assert property ($fell(alarmOn) |-> $past(nvmWrEn)
        && nvmWrCause == 3'h0 && dispCode == 8'h01)
        else $error("lockout left without restart");
    a_write_pulse: assert property (nvmWrEn |=> !nvmWrEn)
        else $error("store write longer than one cycle");
    a_lock_loads: assert property (alarmOn |-> !motorOn
        && !ignitionOn && !firstFuelValve && !secondFuelValve)
        else $error("load on during lockout");
    a_run_loads: assert property (dispCode == 8'h07 |-> motorOn
        && firstFuelValve && secondFuelValve && !ignitionOn && !alarmOn)
        else $error("run code with wrong loads");
    a_supply_cut: assert property (supplyLow [*7] |-> !motorOn
        && !firstFuelValve)
        else $error("burner kept on under low supply");
    a_v2_delay: assert property ($rose(secondFuelValve) |->
        v1Cnt_q >= V2_CYC - 2 && v1Cnt_q <= V2_CYC + 2)
        else $error("second valve delay wrong");
    a_ign_time: assert property ($fell(ignitionOn) && firstFuelValve |->
        v1Cnt_q >= IGN_CYC - 2 && v1Cnt_q <= IGN_CYC + 2)
        else $error("ignition time after first valve wrong");
    a_early_reset: assert property (alarmOn && dispCode[7:4] == 4'h2
        |-> lockCnt_q >= LOCK_CYC - 2)
        else $error("resettable too early");
    a_ready_code: assert property (alarmOn && lockCnt_q >= LOCK_CYC + 3
        |-> dispCode[7:4] == 4'h2)
        else $error("ready-to-reset code missing");
    a_lock_fall: assert property ($fell(alarmOn) && !supplyLow
        |-> ($past(dispCode) & 8'hF0) == 8'h20 || $past(dispCode) == 8'h10)
        else $error("lockout left before resettable");
endmodule : bss_seq_checker

bind bss_sequencer bss_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .heatDemand(heatDemand),
    .flameSeen(flameSeen), .buttonPressed(buttonPressed),
    .supplyLow(supplyLow), .nvmCauseIn(nvmCauseIn), .motorOn(motorOn),
    .ignitionOn(ignitionOn), .firstFuelValve(firstFuelValve),
    .secondFuelValve(secondFuelValve), .alarmOn(alarmOn),
    .dispCode(dispCode), .segTens(segTens), .segOnes(segOnes),
    .nvmWrEn(nvmWrEn), .nvmWrCause(nvmWrCause)
);

// ==== bss_sequencer_tb.sv ====
// self-checking bench for the burner safety sequencer
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
    errCount++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end end
module bss_sequencer_tb;
    import bss_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic heatDemand = 1'b0;
    logic buttonPressed = 1'b0;
    logic supplyLow = 1'b0;
    logic noFuel = 1'b0;
    logic strayLight = 1'b0;
    logic valveLeak = 1'b0;
    logic flameSeen, motorOn, ignitionOn, firstFuelValve, secondFuelValve;
    logic alarmOn, nvmWrEn;
    logic [2:0] nvmCauseIn, nvmWrCause;
    logic [7:0] dispCode;
    logic [6:0] segTens, segOnes;
    int errCount = 0;
    int samplesChecked = 0;

    always #25 clk_sys = ~clk_sys;

    bss_sequencer #(.TICK_CYCLES(T)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .heatDemand(heatDemand), .flameSeen(flameSeen),
        .buttonPressed(buttonPressed), .supplyLow(supplyLow),
        .nvmCauseIn(nvmCauseIn), .motorOn(motorOn), .ignitionOn(ignitionOn),
        .firstFuelValve(firstFuelValve), .secondFuelValve(secondFuelValve),
        .alarmOn(alarmOn), .dispCode(dispCode), .segTens(segTens),
        .segOnes(segOnes), .nvmWrEn(nvmWrEn), .nvmWrCause(nvmWrCause));
    bss_burner_model u_model (.clk_sys(clk_sys), .ignitionOn(ignitionOn),
        .firstFuelValve(firstFuelValve), .nvmWrEn(nvmWrEn),
        .nvmWrCause(nvmWrCause), .noFuel(noFuel), .strayLight(strayLight),
        .valveLeak(valveLeak), .flameSeen(flameSeen),
        .nvmCauseIn(nvmCauseIn));

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic waitCode(input logic [7:0] code, input int lim);
        int n = 0;
        while (dispCode !== code && n < lim) begin
            step(1);
            n++;
        end
        `CHK(dispCode, code)
    endtask : waitCode

    // length of one phase in cycles, from its code appearing
    task automatic phase(input logic [7:0] code, input int secs);
        int n = 0;
        waitCode(code, 4 * T);
        while (dispCode === code && n < secs * T + 9) begin
            step(1);
            n++;
        end
        `CHK(n >= secs * T - 2 && n <= secs * T + 2, 1'b1)
    endtask : phase

    task automatic press(input int hold);
        buttonPressed = 1'b1;
        step(hold);
        buttonPressed = 1'b0;
        step(4);
    endtask : press

    task automatic clearLock(input logic [7:0] code);
        waitCode(code, 62 * T);
        press(6);
        waitCode(CODE_POWERUP, 8);
        waitCode(CODE_READY, 2 * T);
        `CHK(nvmCauseIn, CAUSE_NONE)
    endtask : clearLock

    task automatic reachRun();
        heatDemand = 1'b1;
        phase(CODE_PREPURGE, 10);
        phase(CODE_STRAY, 5);
        phase(CODE_IGNITION, 7);
        phase(CODE_POSTIGN, 15);
        `CHK({dispCode, secondFuelValve}, {CODE_RUN, 1'b1})
    endtask : reachRun

    task automatic tNormal();
        reachRun();
        heatDemand = 1'b0;
        phase(CODE_POSTPURGE, 20);
        `CHK({dispCode, motorOn}, {CODE_READY, 1'b0})
    endtask : tNormal

    task automatic tRecycle();
        reachRun();
        noFuel = 1'b1;
        waitCode(CODE_PREPURGE, 12);
        `CHK({alarmOn, firstFuelValve}, 2'b00)
        noFuel = 1'b0;
        heatDemand = 1'b0;
        waitCode(CODE_READY, 8);
    endtask : tRecycle

    task automatic tStray();
        strayLight = 1'b1;
        heatDemand = 1'b1;
        waitCode(CODE_STRAY_LIGHT, 16 * T);
        heatDemand = 1'b0;
        strayLight = 1'b0;
        step(4);
        `CHK(nvmCauseIn, CAUSE_STRAY_LIGHT)
        step(20 * T);
        press(6);
        `CHK(dispCode, CODE_STRAY_LIGHT)
        clearLock(8'h23);
    endtask : tStray

    task automatic tNoFlame();
        noFuel = 1'b1;
        heatDemand = 1'b1;
        waitCode(CODE_IGNITION, 16 * T);
        phase(CODE_IGNITION, 7);
        `CHK(dispCode, CODE_NO_FLAME)
        heatDemand = 1'b0;
        noFuel = 1'b0;
        rst = 1'b1;
        step(4);
        rst = 1'b0;
        waitCode(CODE_NO_FLAME, 3 * T);
        clearLock(8'h24);
    endtask : tNoFlame

    task automatic tFlameOff();
        reachRun();
        heatDemand = 1'b0;
        waitCode(CODE_POSTPURGE, 8);
        valveLeak = 1'b1;
        waitCode(CODE_FLAME_OFF, 2 * T);
        valveLeak = 1'b0;
        clearLock(8'h22);
    endtask : tFlameOff

    task automatic tManual();
        heatDemand = 1'b1;
        waitCode(CODE_PREPURGE, 8);
        press(2 * T);
        `CHK(dispCode, CODE_PREPURGE)
        press(5 * T);
        waitCode(CODE_MANUAL, 8);
        heatDemand = 1'b0;
        clearLock(8'h21);
    endtask : tManual

    task automatic tSupply();
        reachRun();
        supplyLow = 1'b1;
        waitCode(CODE_LOW_SUPPLY, 8);
        press(6);
        `CHK({alarmOn, nvmCauseIn}, {1'b1, CAUSE_LOW_SUPPLY})
        heatDemand = 1'b0;
        supplyLow = 1'b0;
        waitCode(CODE_POWERUP, 8);
        waitCode(CODE_READY, 2 * T);
    endtask : tSupply

    task automatic summarize();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        step(4);
        rst = 1'b0;
        `CHK({dispCode, segTens, segOnes}, {CODE_POWERUP, 7'h3F, 7'h06})
        waitCode(CODE_READY, 2 * T);
        `CHK({segTens, segOnes}, {7'h3F, 7'h5B})
        tNormal();
        tRecycle();
        tStray();
        tNoFlame();
        tFlameOff();
        tManual();
        tSupply();
        summarize();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        errCount++;
        summarize();
    end
endmodule : bss_sequencer_tb
